// ---- logic/ftrm_regs.v ----
`include "ftrm_defs.vh"

// Overview of operation
// - Part identity at 0x3D, read-only
// - Maker identity at 0x3E, read-only
// - Revision in low nibble of 0x3F
// - Bit 7 of 0x3F enables overtemp fan drive
// - First configuration resets to 0x90
// - Second configuration resets to 0x7F
// - Both status registers reset to zero
// - Fan characteristics one resets to 0x5D
// - Fan speed config and filter reset 0x55
// - Local start and span resets to 0x41
// - Remote start and span resets to 0x61
// - 0x08 holds latest tach period count
// - Flag slow fan when count exceeds limit
// - 0x0A, 0x0B give temperature upper bits
// - 0x06 read-only extra resolution bits
// - Offset registers at 0x0D and 0x0E
// - Local limits reset 60, 0, 70
// - Remote limits reset 80, 0, 100
// - Config two bit 7 resets, self-clears
module ftrm_regs #(
  parameter [7:0] PART_ID = 8'h5a, // Arbitrary value
  parameter [7:0] MAKER_ID = 8'ha5, // Arbitrary value
  parameter [3:0] REVISION = 4'h1 // Arbitrary value
) (
  // Clock, reset, enable
  input wire sys_clk,
  input wire reset_n,
  input wire clk_en,
  // Register access port from the serial engine
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Measurement results, same clock domain
  input wire tach_valid,
  input wire [7:0] tach_count,
  input wire temp_valid,
  input wire [7:0] local_temp,
  input wire [7:0] remote_temp,
  input wire [7:0] extra_bits,
  input wire alarm_speed,
  // Configuration and status towards the block
  output reg [7:0] config_one,
  output reg [7:0] config_two,
  output reg [7:0] fan_characteristics_one,
  output reg [7:0] fan_speed_config,
  output reg [7:0] fan_filter,
  output reg [7:0] local_start_and_span,
  output reg [7:0] remote_start_and_span,
  output reg [7:0] local_temp_offset,
  output reg [7:0] remote_temp_offset,
  output reg overtemp_fan_en,
  output reg fan_slow,
  output reg software_device_reset
);

  // ==========================================================
  // Storage
  // Status bits live in the generate block further down
  // Measured values
  reg [7:0] tach_r;
  reg [7:0] ltemp_r;
  reg [7:0] rtemp_r;
  reg [7:0] xres_r;
  // Limits
  reg [7:0] tlim_r;
  reg [7:0] lhi_r;
  reg [7:0] llo_r;
  reg [7:0] lot_r;
  reg [7:0] rhi_r;
  reg [7:0] rlo_r;
  reg [7:0] rot_r;
  // Combinational helpers
  reg [7:0] stat1_set;
  reg [7:0] stat2_set;
  reg [7:0] rd_nxt;
  wire init;
  wire wr;
  wire rd_take;

  // Write strobe for one address
  function wsel;
    input [7:0] a;
    input [7:0] target;
    begin
      wsel = (a == target);
    end
  endfunction

  // Signed compare helpers; limits and readings are two's
  // complement, so an unsigned compare would miss sub-zero
  function above;
    input [7:0] val;
    input [7:0] lim;
    begin
      above = $signed(val) > $signed(lim);
    end
  endfunction

  function below;
    input [7:0] val;
    input [7:0] lim;
    begin
      below = $signed(val) < $signed(lim);
    end
  endfunction

  // Tach counts are unsigned; equal to the limit is still fine
  function slow_count;
    input [7:0] cnt;
    input [7:0] lim;
    begin
      slow_count = cnt > lim;
    end
  endfunction

  // Offsets that take host writes; all others are read-only,
  // reserved or unmapped and keep their contents
  function writable;
    input [7:0] a;
    begin
      case (a)
        `FTRM_A_CFG1: writable = 1'b1;
        `FTRM_A_CFG2: writable = 1'b1;
        `FTRM_A_TACH: writable = 1'b1;
        `FTRM_A_LOFS: writable = 1'b1;
        `FTRM_A_ROFS: writable = 1'b1;
        `FTRM_A_TLIM: writable = 1'b1;
        `FTRM_A_LHI: writable = 1'b1;
        `FTRM_A_LLO: writable = 1'b1;
        `FTRM_A_LOT: writable = 1'b1;
        `FTRM_A_RHI: writable = 1'b1;
        `FTRM_A_RLO: writable = 1'b1;
        `FTRM_A_ROT: writable = 1'b1;
        `FTRM_A_FCHAR: writable = 1'b1;
        `FTRM_A_FSPD: writable = 1'b1;
        `FTRM_A_FFILT: writable = 1'b1;
        `FTRM_A_LSPAN: writable = 1'b1;
        `FTRM_A_RSPAN: writable = 1'b1;
        `FTRM_A_OTREV: writable = 1'b1;
        default: writable = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================
  // Identity and revision, fixed at build time; the host
  // can read but never change them
  localparam [7:0] PART_CODE = PART_ID;
  localparam [7:0] MAKER_CODE = MAKER_ID;
  localparam [7:0] OTREV_RO = {4'h0, REVISION};

  // Hard or soft reset both restore defaults
  assign init = !reset_n || software_device_reset;
  assign wr = reg_wr && clk_en && writable(reg_addr);
  // A read in the soft reset cycle is dropped, as writes are,
  // so read data never shows a half-reset bank
  assign rd_take = clk_en && reg_rd && !software_device_reset;

  // ==========================================================
  // Event sources for the sticky status bits
  always @* begin
    stat1_set = 8'h00;
    stat2_set = 8'h00;
    // Fan side
    stat1_set[`FTRM_B_ALARM] = alarm_speed;
    stat1_set[`FTRM_B_FANF] = tach_valid && slow_count(tach_count,
      tlim_r);
    // Temperature side, judged only on a fresh result
    if (temp_valid) begin
      stat1_set[`FTRM_B_RHI] = above(remote_temp, rhi_r);
      stat1_set[`FTRM_B_RLO] = below(remote_temp, rlo_r);
      stat1_set[`FTRM_B_ROT] = above(remote_temp, rot_r);
      stat2_set[`FTRM_B_LHI] = above(local_temp, lhi_r);
      stat2_set[`FTRM_B_LLO] = below(local_temp, llo_r);
      stat2_set[`FTRM_B_LOT] = above(local_temp, lot_r);
    end
  end

  // ==========================================================
  // Host-writable registers; soft reset bit self-clears
  always @(posedge sys_clk) begin
    if (init) begin
      config_one <= `FTRM_R_CFG1;
      config_two <= `FTRM_R_CFG2;
      fan_characteristics_one <= `FTRM_R_FCHAR;
      fan_speed_config <= `FTRM_R_FSPD;
      fan_filter <= `FTRM_R_FFILT;
      local_start_and_span <= `FTRM_R_LSPAN;
      remote_start_and_span <= `FTRM_R_RSPAN;
      local_temp_offset <= `FTRM_R_ZERO;
      remote_temp_offset <= `FTRM_R_ZERO;
    end else if (clk_en) begin
      if (wr) begin
        // Only writable offsets are listed; others ignore writes
        case (reg_addr)
          // Configuration
          `FTRM_A_CFG1: config_one <= reg_wdata;
          `FTRM_A_CFG2: config_two <= {1'b0, reg_wdata[6:0]};
          // Fan control
          `FTRM_A_FCHAR: fan_characteristics_one <= reg_wdata;
          `FTRM_A_FSPD: fan_speed_config <= reg_wdata;
          `FTRM_A_FFILT: fan_filter <= reg_wdata;
          `FTRM_A_LSPAN: local_start_and_span <= reg_wdata;
          `FTRM_A_RSPAN: remote_start_and_span <= reg_wdata;
          // Offsets
          `FTRM_A_LOFS: local_temp_offset <= reg_wdata;
          `FTRM_A_ROFS: remote_temp_offset <= reg_wdata;
          default: config_one <= config_one;
        endcase
      end
    end
  end

  // ==========================================================
  // Limit registers; kept apart as they feed the comparators
  always @(posedge sys_clk) begin
    if (init) begin
      tlim_r <= `FTRM_R_TLIM;
      lhi_r <= `FTRM_R_LHI;
      llo_r <= `FTRM_R_LLO;
      lot_r <= `FTRM_R_LOT;
      rhi_r <= `FTRM_R_RHI;
      rlo_r <= `FTRM_R_RLO;
      rot_r <= `FTRM_R_ROT;
    end else if (wr) begin
      case (reg_addr)
        `FTRM_A_TLIM: tlim_r <= reg_wdata;
        `FTRM_A_LHI: lhi_r <= reg_wdata;
        `FTRM_A_LLO: llo_r <= reg_wdata;
        `FTRM_A_LOT: lot_r <= reg_wdata;
        `FTRM_A_RHI: rhi_r <= reg_wdata;
        `FTRM_A_RLO: rlo_r <= reg_wdata;
        `FTRM_A_ROT: rot_r <= reg_wdata;
        default: tlim_r <= tlim_r;
      endcase
    end
  end

  // ==========================================================
  // Soft reset pulse; lasts one cycle because init clears it.
  // Any request in that cycle is lost, a host must wait one
  always @(posedge sys_clk) begin
    if (init) begin
      software_device_reset <= `FTRM_R_BIT;
    end else if (clk_en) begin
      software_device_reset <= wr && wsel(reg_addr, `FTRM_A_CFG2)
        && reg_wdata[`FTRM_B_SWRST];
    end
  end

  // ==========================================================
  // Overtemp-to-fan enable, the only stored bit of 0x3F
  always @(posedge sys_clk) begin
    if (init) begin
      overtemp_fan_en <= `FTRM_R_BIT;
    end else if (wr && wsel(reg_addr, `FTRM_A_OTREV)) begin
      overtemp_fan_en <= reg_wdata[`FTRM_B_OTFAN];
    end
  end

  // ==========================================================
  // Measured values; a fresh count beats a host write
  always @(posedge sys_clk) begin
    if (init) begin
      tach_r <= `FTRM_R_ZERO;
      ltemp_r <= `FTRM_R_ZERO;
      rtemp_r <= `FTRM_R_ZERO;
      xres_r <= `FTRM_R_ZERO;
      fan_slow <= 1'b0;
    end else if (clk_en) begin
      if (tach_valid) begin
        tach_r <= tach_count;
        fan_slow <= slow_count(tach_count, tlim_r);
      end else if (wr && wsel(reg_addr, `FTRM_A_TACH)) begin
        tach_r <= reg_wdata;
      end
      // Temperature results move together
      if (temp_valid) begin
        ltemp_r <= local_temp;
        rtemp_r <= remote_temp;
        xres_r <= extra_bits;
      end
    end
  end

  // ==========================================================
  // Sticky status, one flop per bit; a new event beats the
  // clear so an event during the read is never lost
  wire clr_one;
  wire clr_two;
  wire [7:0] status_one_w;
  wire [7:0] status_two_w;
  genvar gi;

  // Clear only on a taken read of that very address
  assign clr_one = rd_take && wsel(reg_addr, `FTRM_A_STAT1);
  assign clr_two = rd_take && wsel(reg_addr, `FTRM_A_STAT2);

  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sticky
      reg one_r;
      reg two_r;
      always @(posedge sys_clk) begin
        if (init) begin
          one_r <= `FTRM_R_BIT;
          two_r <= `FTRM_R_BIT;
        end else if (clk_en) begin
          one_r <= stat1_set[gi] | (one_r & !clr_one);
          two_r <= stat2_set[gi] | (two_r & !clr_two);
        end
      end
      assign status_one_w[gi] = one_r;
      assign status_two_w[gi] = two_r;
    end
  endgenerate

  // ==========================================================
  // Read mux; unmapped and factory test read as zero
  always @* begin
    case (reg_addr)
      // Configuration and status
      `FTRM_A_CFG1: rd_nxt = config_one;
      `FTRM_A_CFG2: rd_nxt = {software_device_reset, config_two[6:0]};
      `FTRM_A_STAT1: rd_nxt = status_one_w;
      `FTRM_A_STAT2: rd_nxt = status_two_w;
      // Measured values
      `FTRM_A_XRES: rd_nxt = xres_r;
      `FTRM_A_TACH: rd_nxt = tach_r;
      `FTRM_A_LTEMP: rd_nxt = ltemp_r;
      `FTRM_A_RTEMP: rd_nxt = rtemp_r;
      // Offsets and limits
      `FTRM_A_LOFS: rd_nxt = local_temp_offset;
      `FTRM_A_ROFS: rd_nxt = remote_temp_offset;
      `FTRM_A_TLIM: rd_nxt = tlim_r;
      `FTRM_A_LHI: rd_nxt = lhi_r;
      `FTRM_A_LLO: rd_nxt = llo_r;
      `FTRM_A_LOT: rd_nxt = lot_r;
      `FTRM_A_RHI: rd_nxt = rhi_r;
      `FTRM_A_RLO: rd_nxt = rlo_r;
      `FTRM_A_ROT: rd_nxt = rot_r;
      // Fan control
      `FTRM_A_FCHAR: rd_nxt = fan_characteristics_one;
      `FTRM_A_FSPD: rd_nxt = fan_speed_config;
      `FTRM_A_FFILT: rd_nxt = fan_filter;
      `FTRM_A_LSPAN: rd_nxt = local_start_and_span;
      `FTRM_A_RSPAN: rd_nxt = remote_start_and_span;
      // Identity
      `FTRM_A_PART: rd_nxt = PART_CODE;
      `FTRM_A_MAKER: rd_nxt = MAKER_CODE;
      `FTRM_A_OTREV: rd_nxt = OTREV_RO | {overtemp_fan_en, 7'h00};
      default: rd_nxt = `FTRM_R_ZERO;
    endcase
  end

  // Registered read data, one cycle after the strobe; a soft
  // reset leaves the last read value standing
  always @(posedge sys_clk) begin
    if (!reset_n)
      reg_rdata <= `FTRM_R_ZERO;
    else if (rd_take)
      reg_rdata <= rd_nxt;
  end

endmodule // ftrm_regs

// ---- logic/ftrm_defs.vh ----
`ifndef FTRM_DEFS_VH
`define FTRM_DEFS_VH

// ============================================================
// Register offsets
`define FTRM_A_CFG1 8'h00
`define FTRM_A_CFG2 8'h01
`define FTRM_A_STAT1 8'h02
`define FTRM_A_STAT2 8'h03
`define FTRM_A_XRES 8'h06
`define FTRM_A_FTEST 8'h07
`define FTRM_A_TACH 8'h08
`define FTRM_A_LTEMP 8'h0a
`define FTRM_A_RTEMP 8'h0b
`define FTRM_A_LOFS 8'h0d
`define FTRM_A_ROFS 8'h0e
`define FTRM_A_TLIM 8'h10
`define FTRM_A_LHI 8'h14
`define FTRM_A_LLO 8'h15
`define FTRM_A_LOT 8'h16
`define FTRM_A_RHI 8'h18
`define FTRM_A_RLO 8'h19
`define FTRM_A_ROT 8'h1a
`define FTRM_A_FCHAR 8'h20
`define FTRM_A_FSPD 8'h22
`define FTRM_A_FFILT 8'h23
`define FTRM_A_LSPAN 8'h24
`define FTRM_A_RSPAN 8'h25
`define FTRM_A_PART 8'h3d
`define FTRM_A_MAKER 8'h3e
`define FTRM_A_OTREV 8'h3f

// ============================================================
// Reset values
`define FTRM_R_CFG1 8'h90
`define FTRM_R_CFG2 8'h7f
`define FTRM_R_STAT 8'h00
`define FTRM_R_TLIM 8'hff
`define FTRM_R_LHI 8'h3c
`define FTRM_R_LLO 8'h00
`define FTRM_R_LOT 8'h46
`define FTRM_R_RHI 8'h50
`define FTRM_R_RLO 8'h00
`define FTRM_R_ROT 8'h64
`define FTRM_R_FCHAR 8'h5d
`define FTRM_R_FSPD 8'h55
`define FTRM_R_FFILT 8'h55
`define FTRM_R_LSPAN 8'h41
`define FTRM_R_RSPAN 8'h61
`define FTRM_R_ZERO 8'h00
`define FTRM_R_BIT 1'b0

// ============================================================
// Field positions
`define FTRM_B_SWRST 7
`define FTRM_B_OTFAN 7
`define FTRM_B_ALARM 0
`define FTRM_B_FANF 1
`define FTRM_B_RHI 2
`define FTRM_B_RLO 3
`define FTRM_B_ROT 4
`define FTRM_B_LHI 0
`define FTRM_B_LLO 1
`define FTRM_B_LOT 2

`endif

// ---- tb/ftrm_chk_assertions.sv ----
// ==========================================
// Register bank checker
module ftrm_chk (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  input wire clk_en,
  // Register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // Tach and outputs
  input wire tach_valid,
  input wire [7:0] tach_count,
  input wire [7:0] config_one,
  input wire [7:0] config_two,
  input wire overtemp_fan_en,
  input wire fan_slow,
  input wire software_device_reset
);
  default clocking @(posedge sys_clk);
  endclocking
  logic [7:0] lim_r;
  logic [7:0] tach_r;
  // Soft reset cycle overrides any request
  wire acc = clk_en && !software_device_reset;
  // Shadows of tach limit and reading; soft reset restores both
  always @(posedge sys_clk) begin
    if (!reset_n || software_device_reset) begin
      lim_r <= 8'hff;
      tach_r <= 8'h00;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == 8'h10) lim_r <= reg_wdata;
      if (tach_valid) tach_r <= tach_count;
      else if (reg_wr && reg_addr == 8'h08) tach_r <= reg_wdata;
    end
  end
  chk_part_read: assert property (disable iff (!reset_n)
    acc && reg_rd && reg_addr == 8'h3d |=> reg_rdata == 8'h5a)
    else $error("part identity read wrong");
  chk_maker_read: assert property (disable iff (!reset_n)
    acc && reg_rd && reg_addr == 8'h3e |=> reg_rdata == 8'ha5)
    else $error("maker identity read wrong");
  chk_rev_read: assert property (disable iff (!reset_n)
    acc && reg_rd && reg_addr == 8'h3f |=> reg_rdata[3:0] == 4'h1)
    else $error("revision field wrong");
  chk_otfan_write: assert property (disable iff (!reset_n)
    acc && reg_wr && reg_addr == 8'h3f
    |=> overtemp_fan_en == $past(reg_wdata[7]))
    else $error("overtemp fan enable not stored");
  chk_reset_vals: assert property (
    !reset_n |=> config_one == 8'h90 && config_two == 8'h7f)
    else $error("configuration defaults wrong");
  chk_swrst_pulse: assert property (disable iff (!reset_n)
    acc && reg_wr && reg_addr == 8'h01 && reg_wdata[7]
    |=> software_device_reset ##1 (!software_device_reset
    && config_two == 8'h7f))
    else $error("soft reset pulse wrong");
  chk_slow_flag: assert property (disable iff (!reset_n)
    acc && tach_valid |=> fan_slow == ($past(tach_count) > $past(lim_r)))
    else $error("slow fan flag wrong");
  chk_tach_read: assert property (disable iff (!reset_n)
    acc && reg_rd && reg_addr == 8'h08 |=> reg_rdata == $past(tach_r))
    else $error("tach reading wrong");
  chk_rdata_hold: assert property (disable iff (!reset_n)
    !(acc && reg_rd) |=> $stable(reg_rdata))
    else $error("read data moved without a read");
endmodule // ftrm_chk

bind ftrm_regs ftrm_chk ftrm_chk_inst (.sys_clk, .reset_n, .clk_en,
  .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .tach_valid,
  .tach_count, .config_one, .config_two, .overtemp_fan_en, .fan_slow,
  .software_device_reset);

// ---- tb/ftrm_host.sv ----
// ==========================================
// Host side of the register port
module ftrm_host (
  // Clock and read data
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  // Requests
  output logic [7:0] reg_addr = 8'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [7:0] reg_wdata = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // One write; fields inverted after so stale data never matches
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
    reg_addr = ~a;
  endtask
  // One read; the factory test place is never addressed
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    q = reg_rdata;
    reg_addr = ~a;
  endtask
endmodule // ftrm_host

// ---- tb/fan_thermal_register_map_bench.sv ----
// ==========================================
// Register bank bench
module fan_thermal_register_map_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic tach_valid = 1'b0;
  logic temp_valid = 1'b0;
  logic [7:0] tach_count = 8'h00;
  logic [23:0] temps = 24'h000000;
  logic [7:0] q;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, overtemp_fan_en, fan_slow;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  // Address and expected value pairs
  logic [15:0] rst_tab [18] = '{16'h0090, 16'h017f, 16'h0200, 16'h0300,
    16'h205d, 16'h2255, 16'h2355, 16'h2441, 16'h2561, 16'h10ff,
    16'h143c, 16'h1500, 16'h1646, 16'h1850, 16'h1900, 16'h1a64,
    16'h3d5a, 16'h3ea5};
  logic [15:0] ro_tab [5] = '{16'h3d5a, 16'h3ea5, 16'h0200, 16'h0600,
    16'h0a00};
  logic [15:0] rw_tab [4] = '{16'h0df6, 16'h0e05, 16'h0833, 16'h107f};
  always #2 sys_clk = ~sys_clk;
  ftrm_regs ftrm_regs_inst (.sys_clk, .reset_n, .clk_en(1'b1), .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .tach_valid, .tach_count,
    .temp_valid, .local_temp(temps[23:16]), .remote_temp(temps[15:8]),
    .extra_bits(temps[7:0]), .alarm_speed(1'b0), .config_one(),
    .config_two(), .fan_characteristics_one(), .fan_speed_config(),
    .fan_filter(), .local_start_and_span(), .remote_start_and_span(),
    .local_temp_offset(), .remote_temp_offset(), .overtemp_fan_en,
    .fan_slow, .software_device_reset());
  ftrm_host ftrm_host_inst (.sys_clk, .reg_rdata, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tach(input logic [7:0] c);
    @(negedge sys_clk);
    tach_count = c;
    tach_valid = 1'b1;
    @(negedge sys_clk);
    tach_valid = 1'b0;
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard well above the run length
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (16) @(negedge sys_clk);
    reset_n = 1'b1;
    foreach (rst_tab[i]) begin
      ftrm_host_inst.rd(rst_tab[i][15:8], q);
      check(q, rst_tab[i][7:0]);
    end
    // Only bit 7 sticks; low nibble stays the revision
    ftrm_host_inst.wr(8'h3f, 8'h8e);
    ftrm_host_inst.rd(8'h3f, q);
    check(q, 8'h81);
    check({7'h00, overtemp_fan_en}, 8'h01);
    foreach (ro_tab[i]) begin
      ftrm_host_inst.wr(ro_tab[i][15:8], ~ro_tab[i][7:0]);
      ftrm_host_inst.rd(ro_tab[i][15:8], q);
      check(q, ro_tab[i][7:0]);
    end
    // Local 30, remote -56 (below low limit)
    @(negedge sys_clk);
    temps = 24'h1ec860;
    temp_valid = 1'b1;
    @(negedge sys_clk);
    temp_valid = 1'b0;
    ftrm_host_inst.rd(8'h0a, q);
    check(q, 8'h1e);
    ftrm_host_inst.rd(8'h0b, q);
    check(q, 8'hc8);
    ftrm_host_inst.rd(8'h06, q);
    check(q, 8'h60);
    foreach (rw_tab[i]) begin
      ftrm_host_inst.wr(rw_tab[i][15:8], rw_tab[i][7:0]);
      ftrm_host_inst.rd(rw_tab[i][15:8], q);
      check(q, rw_tab[i][7:0]);
    end
    // Count one above the limit, then equal to it
    tach(8'h80);
    check({7'h00, fan_slow}, 8'h01);
    ftrm_host_inst.rd(8'h08, q);
    check(q, 8'h80);
    ftrm_host_inst.rd(8'h02, q);
    check(q, 8'h0a);
    tach(8'h7f);
    check({7'h00, fan_slow}, 8'h00);
    // Soft reset brings written registers back
    ftrm_host_inst.wr(8'h01, 8'h80);
    ftrm_host_inst.rd(8'h0d, q);
    check(q, 8'h00);
    ftrm_host_inst.rd(8'h10, q);
    check(q, 8'hff);
    ftrm_host_inst.rd(8'h01, q);
    check(q, 8'h7f);
    give_verdict();
  end
endmodule // fan_thermal_register_map_bench
